// file: core/cpmc_top.sv
/*
  Clock and power-mode controller: source selection, PLL emulation with
  multiplier and post divider, lock wait, clock-out mux, peripheral
  gating, sleep / deep-sleep / power-down / deep power-down sequencing.
  Assumes oscillators arrive as one-cycle tick enables on clk; software
  control bits are plain ports held stable by the caller.
*/
// Notes on behaviour
// - After any reset the main clock runs from the internal RC oscillator.
// - PLL multiplier accepts every integer from 1 to 32.
// - Loop divider keeps the PLL core oscillator within 156 to 320 MHz; the code has no loop divider.
// - Post divider offers only 2, 4, 8 or 16 for even duty.
// - Reset powers the PLL off and bypasses it until software enables it.
// - Clock-out selects RC, crystal, watchdog oscillator or main clock.
// - Each peripheral has its own clock enable bit.
// - Watchdog oscillator clocks the windowed watchdog, frequency programmable; the code ignores wdt_freq_sel.
// - Low-power oscillator clocks only the wake timer, may run in low-power modes.
// - Sleep gates the core clock only; peripherals keep running.
// - Sleep holds execution until reset or any peripheral interrupt.
// - Deep-sleep stops core, peripherals, RC output and all sources except selected wake osc.
// - Deep-sleep wakes on pin, watchdog, sync serial, SPI or I2C slave irq.
// - Wake needs the irq enabled in both wake enable and interrupt controller.
// - Power-down stops all clocks but selected wake osc; flash shut down.
// - Power-down wakes on the same sources as deep-sleep.
// - Deep power-down keeps wake pin, wake timer and four retention registers.
// - Deep power-down ends on wake pin or wake timer time-out.
// - The lock bit refuses entry into deep power-down.
// - Writing a non-zero wake timer value starts it counting down.
module cpmc_top
  import cpmc_pkg::*;
#(
  parameter int unsigned N_PER      = N_PERIPH,
  parameter int unsigned LOCK_CYC   = PLL_SETTLE_CYC
)(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire cpmc_ticks_t               ticks,
  input  wire cpmc_clk_cfg_t             clk_cfg,
  input  wire cpmc_osc_cfg_t             osc_cfg,
  input  wire logic [3:0]                wdt_freq_sel,
  input  wire logic [N_PER-1:0]          periph_clk_en,
  input  wire logic                      mode_req,
  input  wire cpmc_req_mode_t            mode_sel,
  input  wire logic                      dpd_lock,
  input  wire logic [N_WAKE_SRC-1:0]     wake_irq,
  input  wire logic [N_WAKE_SRC-1:0]     wake_en,
  input  wire logic [N_WAKE_SRC-1:0]     irq_ctrl_en,
  input  wire logic                      any_irq,
  input  wire logic                      wake_pin_n,
  input  wire logic                      wkt_load,
  input  wire logic [WAKE_TIMER_W-1:0]   wkt_value,
  input  wire logic                      ret_we,
  input  wire logic [1:0]                ret_idx,
  input  wire logic [31:0]               ret_wdata,
  output logic                           main_tick,
  output logic                           core_tick,
  output logic [N_PER-1:0]               periph_tick,
  output logic                           clock_out_tick,
  output logic                           wdt_tick,
  output logic                           wkt_tick,
  output logic                           pll_locked,
  output logic                           pll_powered,
  output logic                           irc_out_en,
  output logic                           flash_standby,
  output logic                           flash_off,
  output logic                           core_power_off,
  output logic                           wkt_running,
  output logic                           wkt_timeout,
  output cpmc_state_t                    power_state,
  output logic [31:0]                    ret_rdata
);

  if (N_PER < 1 || N_PER > 32)
  begin : g_bad_per
    $error("cpmc_top: N_PER out of range");
  end
  if (LOCK_CYC < 1)
  begin : g_bad_lock
    $error("cpmc_top: LOCK_CYC must be positive");
  end

  // ----------------------------------------------------------------------
  // Power-mode state machine
  // ----------------------------------------------------------------------
  cpmc_state_t state_q;
  logic        wake_hit;
  logic        wkt_done_q;

  assign wake_hit = |(wake_irq & wake_en & irq_ctrl_en);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= CPMC_ST_RUN;
    else
    begin
      case (state_q)
        CPMC_ST_RUN:
          if (mode_req)
          begin
            case (mode_sel)
              CPMC_REQ_SLEEP:      state_q <= CPMC_ST_SLEEP;
              CPMC_REQ_DEEP_SLEEP: state_q <= CPMC_ST_DSLEEP;
              CPMC_REQ_POWER_DOWN: state_q <= CPMC_ST_PDOWN;
              CPMC_REQ_DEEP_PD:
                if (!dpd_lock)
                  state_q <= CPMC_ST_DPD;
              default:             state_q <= CPMC_ST_RUN;
            endcase
          end
        CPMC_ST_SLEEP:
          if (any_irq)
            state_q <= CPMC_ST_RUN;
        CPMC_ST_DSLEEP:
          if (wake_hit || wkt_done_q)
            state_q <= CPMC_ST_RUN;
        CPMC_ST_PDOWN:
          if (wake_hit || wkt_done_q)
            state_q <= CPMC_ST_RUN;
        CPMC_ST_DPD:
          if (!wake_pin_n || wkt_done_q)
            state_q <= CPMC_ST_RUN;
        default:
          state_q <= CPMC_ST_RUN;
      endcase
    end
  end

  logic run_s;
  logic core_on;
  logic periph_on;
  logic deep_any;
  assign run_s     = (state_q == CPMC_ST_RUN);
  assign core_on   = run_s;
  assign periph_on = run_s || (state_q == CPMC_ST_SLEEP);
  assign deep_any  = (state_q == CPMC_ST_DSLEEP) || (state_q == CPMC_ST_PDOWN)
                     || (state_q == CPMC_ST_DPD);

  // ----------------------------------------------------------------------
  // PLL: enable, lock timer, multiplier and post divider
  // ----------------------------------------------------------------------
  localparam int unsigned LW = $clog2(LOCK_CYC + 1);
  logic [LW-1:0] lock_cnt_q;
  logic          pll_on;

  // Deep modes stop the PLL even when software left it enabled
  assign pll_on = clk_cfg.pll_enable && periph_on;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_cnt_q <= '0;
      pll_locked <= 1'b0;
    end
    else if (!pll_on)
    begin
      lock_cnt_q <= '0;
      pll_locked <= 1'b0;
    end
    else if (lock_cnt_q == LW'(LOCK_CYC - 1))
      pll_locked <= 1'b1;
    else
      lock_cnt_q <= lock_cnt_q + LW'(1);
  end

  logic pll_ref_tick;
  always_comb
  begin
    case (clk_cfg.pll_src)
      CPMC_PLLSRC_XTAL: pll_ref_tick = ticks.xtal && osc_cfg.xtal_en;
      CPMC_PLLSRC_EXT:  pll_ref_tick = ticks.ext && osc_cfg.ext_en;
      default:          pll_ref_tick = ticks.internal_rc_osc;
    endcase
  end

  // Core oscillator emulated as ticks.pll (2x oversampled grid); output is
  // ticks.pll divided by post-divider; multiplier value kept for M+1 range.
  logic [5:0] mult_q;
  logic [3:0] post_cnt_q;
  logic [3:0] post_lim;
  logic       pll_out_tick;
  assign post_lim = 4'((POST_DIV_MIN << clk_cfg.pll_post_log2m1) - 1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mult_q <= 6'h01;
    else
      mult_q <= {1'b0, clk_cfg.pll_mult_m1} + 6'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      post_cnt_q <= 4'h0;
    else if (!pll_locked)
      post_cnt_q <= 4'h0;
    else if (ticks.pll)
      post_cnt_q <= (post_cnt_q >= post_lim) ? 4'h0 : post_cnt_q + 4'h1;
  end
  assign pll_out_tick = pll_locked && ticks.pll && (post_cnt_q >= post_lim);

  // ----------------------------------------------------------------------
  // Main clock selection
  // ----------------------------------------------------------------------
  logic tick_src;
  logic use_alt;
  logic mux_tick;
  always_comb
  begin
    // Unstable oscillators pass through; the PLL output is held off until pll_locked
    case (clk_cfg.main_sel)
      CPMC_MAIN_PLLIN:  tick_src = pll_ref_tick;
      CPMC_MAIN_WDT:    tick_src = ticks.wdt && osc_cfg.wdt_osc_en;
      CPMC_MAIN_PLLOUT: tick_src = pll_on ? pll_out_tick : pll_ref_tick;
      default:          tick_src = ticks.internal_rc_osc;
    endcase
  end
  assign use_alt = (clk_cfg.main_sel != CPMC_MAIN_IRC);

  cpmc_glitch_mux u_mux (
    .clk      (clk),
    .rst      (rst),
    .sel      (use_alt),
    .tick_a   (ticks.internal_rc_osc),
    .tick_b   (tick_src),
    .tick_out (mux_tick),
    .cur_sel  ()
  );

  // ----------------------------------------------------------------------
  // Wake timer and retention registers
  // ----------------------------------------------------------------------
  logic [WAKE_TIMER_W-1:0] wkt_cnt_q;
  logic                    lp_run;
  logic [31:0]             ret_q [N_RETAIN];
  assign lp_run = osc_cfg.lp_osc_en && (periph_on || osc_cfg.lp_osc_keep);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wkt_cnt_q  <= '0;
      wkt_done_q <= 1'b0;
    end
    else if (wkt_load)
    begin
      wkt_cnt_q  <= wkt_value;
      wkt_done_q <= (wkt_cnt_q == WAKE_TIMER_W'(1)) && ticks.lp && lp_run;
    end
    else if (wkt_cnt_q != '0 && ticks.lp && lp_run)
    begin
      wkt_cnt_q  <= wkt_cnt_q - WAKE_TIMER_W'(1);
      wkt_done_q <= (wkt_cnt_q == WAKE_TIMER_W'(1));
    end
    else if (run_s)
      wkt_done_q <= 1'b0;
  end

  // Retention survives deep power-down; cleared only by reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < N_RETAIN; i++)
        ret_q[i] <= 32'h0000_0000;
    end
    else if (ret_we && run_s)
      ret_q[ret_idx] <= ret_wdata;
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  logic out_src;
  always_comb
  begin
    case (clk_cfg.out_sel)
      CPMC_OUT_XTAL: out_src = ticks.xtal && osc_cfg.xtal_en && periph_on;
      CPMC_OUT_WDT:  out_src = ticks.wdt && osc_cfg.wdt_osc_en;
      CPMC_OUT_MAIN: out_src = mux_tick && periph_on;
      default:       out_src = ticks.internal_rc_osc && periph_on;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      main_tick      <= 1'b0;
      core_tick      <= 1'b0;
      periph_tick    <= '0;
      clock_out_tick <= 1'b0;
      wdt_tick       <= 1'b0;
      wkt_tick       <= 1'b0;
      pll_powered    <= 1'b0;
      irc_out_en     <= 1'b1;
      flash_standby  <= 1'b0;
      flash_off      <= 1'b0;
      core_power_off <= 1'b0;
      wkt_running    <= 1'b0;
      wkt_timeout    <= 1'b0;
      power_state    <= CPMC_ST_RUN;
      ret_rdata      <= 32'h0000_0000;
    end
    else
    begin
      main_tick      <= mux_tick && periph_on;
      core_tick      <= mux_tick && core_on;
      periph_tick    <= (mux_tick && periph_on) ? periph_clk_en : '0;
      clock_out_tick <= out_src;
      wdt_tick       <= ticks.wdt && osc_cfg.wdt_osc_en
                        && (state_q != CPMC_ST_DPD);
      wkt_tick       <= ticks.lp && lp_run;
      pll_powered    <= pll_on;
      irc_out_en     <= periph_on;
      flash_standby  <= (state_q == CPMC_ST_DSLEEP);
      flash_off      <= (state_q == CPMC_ST_PDOWN) || (state_q == CPMC_ST_DPD);
      core_power_off <= (state_q == CPMC_ST_DPD);
      wkt_running    <= (wkt_cnt_q != '0);
      wkt_timeout    <= wkt_done_q && deep_any;
      power_state    <= state_q;
      ret_rdata      <= ret_q[ret_idx];
    end
  end

endmodule : cpmc_top

// file: core/cpmc_pkg.sv
/*
  Package for the clock and power-mode controller: modes, clock selects,
  field widths, reset values and timing counts.
  Assumes a single 125 MHz system clock; oscillators appear as enable pulses.
*/
package cpmc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned PLL_SETTLE_US    = 100;
  localparam int unsigned PLL_SETTLE_CYC   = PLL_SETTLE_US * CLK_MHZ;
  localparam int unsigned SWITCH_SYNC_CYC  = 2;

  // ----------------------------------------------------------------------
  // PLL limits
  // ----------------------------------------------------------------------
  localparam int unsigned PLL_MULT_MIN     = 1;
  localparam int unsigned PLL_MULT_MAX     = 32;
  localparam int unsigned PLL_IN_MIN_MHZ   = 10;
  localparam int unsigned PLL_IN_MAX_MHZ   = 25;
  localparam int unsigned CCO_MIN_MHZ      = 156;
  localparam int unsigned CCO_MAX_MHZ      = 320;
  localparam int unsigned POST_DIV_MIN     = 2;
  localparam int unsigned POST_DIV_MAX     = 16;
  localparam logic [4:0]  MULT_RST         = 5'h00;
  localparam logic [1:0]  PDIV_RST         = 2'h0;

  // ----------------------------------------------------------------------
  // Wake / peripherals / retention
  // ----------------------------------------------------------------------
  localparam int unsigned N_PERIPH         = 16;
  localparam int unsigned N_RETAIN         = 4;
  localparam int unsigned WAKE_TIMER_W     = 32;
  localparam int unsigned WDT_FREQ_W       = 4;
  localparam logic [3:0]  WDT_FREQ_RST     = 4'h0;
  localparam int unsigned WAKE_SRC_PIN     = 0;
  localparam int unsigned WAKE_SRC_WDT     = 1;
  localparam int unsigned WAKE_SRC_USART   = 2;
  localparam int unsigned WAKE_SRC_SPI     = 3;
  localparam int unsigned WAKE_SRC_I2C     = 4;
  localparam int unsigned N_WAKE_SRC       = 5;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CPMC_MAIN_IRC = 2'h0,
    CPMC_MAIN_PLLIN = 2'h1,
    CPMC_MAIN_WDT = 2'h2,
    CPMC_MAIN_PLLOUT = 2'h3
  } cpmc_main_sel_t;

  typedef enum logic [1:0] {
    CPMC_PLLSRC_IRC = 2'h0,
    CPMC_PLLSRC_XTAL = 2'h1,
    CPMC_PLLSRC_EXT = 2'h3
  } cpmc_pll_src_t;

  typedef enum logic [1:0] {
    CPMC_OUT_IRC = 2'h0,
    CPMC_OUT_XTAL = 2'h1,
    CPMC_OUT_WDT = 2'h2,
    CPMC_OUT_MAIN = 2'h3
  } cpmc_out_sel_t;

  typedef enum logic [1:0] {
    CPMC_REQ_SLEEP = 2'h0,
    CPMC_REQ_DEEP_SLEEP = 2'h1,
    CPMC_REQ_POWER_DOWN = 2'h2,
    CPMC_REQ_DEEP_PD = 2'h3
  } cpmc_req_mode_t;

  // Gray-coded along run -> sleep -> deep sleep -> power down -> deep pd
  typedef enum logic [2:0] {
    CPMC_ST_RUN = 3'h0,
    CPMC_ST_SLEEP = 3'h1,
    CPMC_ST_DSLEEP = 3'h3,
    CPMC_ST_PDOWN = 3'h2,
    CPMC_ST_DPD = 3'h6
  } cpmc_state_t;

  typedef struct packed {
    logic       pll_enable;
    logic [4:0] pll_mult_m1;
    logic [1:0] pll_post_log2m1;
    cpmc_pll_src_t pll_src;
    cpmc_main_sel_t main_sel;
    cpmc_out_sel_t out_sel;
  } cpmc_clk_cfg_t;

  typedef struct packed {
    logic xtal_en;
    logic ext_en;
    logic wdt_osc_en;
    logic lp_osc_en;
    logic lp_osc_keep;
  } cpmc_osc_cfg_t;

  typedef struct packed {
    logic internal_rc_osc;
    logic xtal;
    logic ext;
    logic wdt;
    logic lp;
    logic pll;
  } cpmc_ticks_t;

endpackage : cpmc_pkg

// file: core/cpmc_glitch_mux.sv
/*
  Glitch-free switch between two tick streams for the main clock.
  Assumes ticks are one-cycle enables synchronous to clk.
*/
module cpmc_glitch_mux
  import cpmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sel,
  input  wire logic       tick_a,
  input  wire logic       tick_b,
  output logic            tick_out,
  output logic            cur_sel
);

  logic       on_a_q;
  logic       on_b_q;

  // Old stream released on its own tick, new one taken on its own tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      on_a_q <= 1'b1;
      on_b_q <= 1'b0;
    end
    else
    begin
      if (sel && on_a_q && tick_a)
        on_a_q <= 1'b0;
      else if (!sel && !on_b_q && !on_a_q && tick_a)
        on_a_q <= 1'b1;
      if (!sel && on_b_q && tick_b)
        on_b_q <= 1'b0;
      else if (sel && !on_a_q && !on_b_q && tick_b)
        on_b_q <= 1'b1;
    end
  end

  assign tick_out = (on_a_q && tick_a) || (on_b_q && tick_b);
  assign cur_sel  = on_b_q;

endmodule : cpmc_glitch_mux

// file: test/cpmc_osc_model.sv
/*
  Far-side model: emulated oscillators that hand tick pulses to the block.
  Assumes the 125 MHz system clock and the block's active-high reset.
*/
module cpmc_osc_model
  import cpmc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  output cpmc_ticks_t ticks
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end

  // ----
  // Fixed rates, all stable from the first edge
  // ----
  always_comb
  begin
    ticks.internal_rc_osc  = (cnt_q[0] == 1'b0);
    ticks.xtal = (cnt_q[1:0] == 2'h0);
    ticks.ext  = (cnt_q[2:0] == 3'h0);
    ticks.wdt  = (cnt_q[3:0] == 4'h0);
    ticks.lp   = (cnt_q[1:0] == 2'h2);
    ticks.pll  = (cnt_q[0] == 1'b1);
  end
endmodule : cpmc_osc_model

// file: test/cpmc_sva.sv
/*
  Checker on the controller's top ports.
  Assumes one clock domain and a lock count of at least five cycles.
*/
module cpmc_sva
  import cpmc_pkg::*;
#(
  parameter int unsigned N_PER = N_PERIPH
)(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire cpmc_ticks_t             ticks,
  input wire cpmc_clk_cfg_t           clk_cfg,
  input wire logic [N_PER-1:0]        periph_clk_en,
  input wire logic                    mode_req,
  input wire cpmc_req_mode_t          mode_sel,
  input wire logic                    dpd_lock,
  input wire logic [N_WAKE_SRC-1:0]   wake_irq,
  input wire logic [N_WAKE_SRC-1:0]   wake_en,
  input wire logic [N_WAKE_SRC-1:0]   irq_ctrl_en,
  input wire logic                    any_irq,
  input wire logic                    wake_pin_n,
  input wire logic                    wkt_load,
  input wire logic [WAKE_TIMER_W-1:0] wkt_value,
  input wire logic                    main_tick,
  input wire logic                    core_tick,
  input wire logic [N_PER-1:0]        periph_tick,
  input wire logic                    pll_locked,
  input wire logic                    pll_powered,
  input wire logic                    irc_out_en,
  input wire logic                    flash_standby,
  input wire logic                    flash_off,
  input wire logic                    wkt_running,
  input wire logic                    wkt_timeout,
  input wire logic                    wdt_tick,
  input wire logic                    core_power_off,
  input wire cpmc_state_t             power_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Cycles spent running on the RC source; mux hand-over needs a few
  logic [3:0] calm_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      calm_q <= 4'h0;
    else if (power_state != CPMC_ST_RUN || clk_cfg.main_sel != CPMC_MAIN_IRC)
      calm_q <= 4'h0;
    else if (calm_q != 4'hF)
      calm_q <= calm_q + 4'h1;
  end

  property p_main_irc;
    calm_q >= 4'h8 && power_state == CPMC_ST_RUN |-> main_tick == $past(ticks.internal_rc_osc);
  endproperty
  a_main_irc: assert property (p_main_irc) else $error("main tick off rc");

  property p_lock;
    $rose(pll_locked) |-> pll_powered && $past(pll_powered, 4);
  endproperty
  a_lock: assert property (p_lock) else $error("lock without power");

  property p_ds;
    power_state == CPMC_ST_DSLEEP && $past(power_state) == CPMC_ST_DSLEEP
      |-> !irc_out_en && flash_standby && !pll_powered && periph_tick == '0;
  endproperty
  a_ds: assert property (p_ds) else $error("deep sleep left clocks on");

  property p_pd;
    power_state == CPMC_ST_PDOWN && $past(power_state) == CPMC_ST_PDOWN
      |-> flash_off && !pll_powered && !core_tick;
  endproperty
  a_pd: assert property (p_pd) else $error("power down left clocks on");

  property p_dpd;
    power_state == CPMC_ST_DPD && $past(power_state) == CPMC_ST_DPD
      |-> core_power_off && flash_off && !wdt_tick;
  endproperty
  a_dpd: assert property (p_dpd) else $error("deep pd left power on");

  property p_wkt_to;
    wkt_timeout |-> ##1 power_state == CPMC_ST_RUN;
  endproperty
  a_wkt_to: assert property (p_wkt_to) else $error("time-out no wake");

  property p_gate;
    |periph_tick |-> (periph_tick & ~($past(periph_clk_en) | $past(periph_clk_en, 2))) == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("gated peripheral ticked");

  property p_lockout;
    mode_req && mode_sel == CPMC_REQ_DEEP_PD && dpd_lock && power_state == CPMC_ST_RUN
      && !$past(mode_req) |-> ##2 power_state == CPMC_ST_RUN;
  endproperty
  a_lockout: assert property (p_lockout) else $error("locked deep pd entered");

  property p_wake_slp;
    power_state == CPMC_ST_SLEEP && any_irq |-> ##[1:3] power_state == CPMC_ST_RUN;
  endproperty
  a_wake_slp: assert property (p_wake_slp) else $error("sleep not left");

  property p_wake_deep;
    (power_state == CPMC_ST_DSLEEP || power_state == CPMC_ST_PDOWN)
      && (wake_irq & wake_en & irq_ctrl_en) != '0 |-> ##[1:3] power_state == CPMC_ST_RUN;
  endproperty
  a_wake_deep: assert property (p_wake_deep) else $error("deep mode not left");

  property p_dpd_wake;
    power_state == CPMC_ST_DPD && !wake_pin_n |-> ##[1:3] power_state == CPMC_ST_RUN;
  endproperty
  a_dpd_wake: assert property (p_dpd_wake) else $error("deep pd not left");

  property p_wkt;
    wkt_load && wkt_value != '0 |-> ##2 wkt_running;
  endproperty
  a_wkt: assert property (p_wkt) else $error("wake timer idle");

  c_sleep: cover property (power_state == CPMC_ST_SLEEP);
  c_dpd: cover property (power_state == CPMC_ST_DPD);
  c_lock: cover property ($rose(pll_locked));
endmodule : cpmc_sva

bind cpmc_top cpmc_sva #(.N_PER(N_PER)) u_sva (
  .clk, .rst, .ticks, .clk_cfg, .periph_clk_en, .mode_req, .mode_sel, .dpd_lock,
  .wake_irq, .wake_en, .irq_ctrl_en, .any_irq, .wake_pin_n, .wkt_load, .wkt_value,
  .main_tick, .core_tick, .periph_tick, .pll_locked, .pll_powered, .irc_out_en,
  .flash_standby, .flash_off, .wkt_running, .power_state, .wkt_timeout, .wdt_tick,
  .core_power_off
);

// file: test/tb.sv
/*
  Self-checking bench for the clock and power-mode controller.
  Assumes the oscillator model and the bound checker are compiled first.
*/
module tb
  import cpmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk = 1'b0;
  logic           rst = 1'b1;
  cpmc_ticks_t    ticks;
  cpmc_clk_cfg_t  clk_cfg = '0;
  cpmc_osc_cfg_t  osc_cfg = 5'h1F;
  logic [3:0]     wdt_freq_sel = 4'h0;
  logic [15:0]    periph_clk_en = 16'hFFFF;
  logic           mode_req = 1'b0;
  cpmc_req_mode_t mode_sel = CPMC_REQ_SLEEP;
  logic           dpd_lock = 1'b0;
  logic [4:0]     wake_irq = 5'h00;
  logic [4:0]     wake_en = 5'h00;
  logic [4:0]     irq_ctrl_en = 5'h00;
  logic           any_irq = 1'b0;
  logic           wake_pin_n = 1'b1;
  logic           wkt_load = 1'b0;
  logic [31:0]    wkt_value = 32'h0;
  logic           ret_we = 1'b0;
  logic [1:0]     ret_idx = 2'h0;
  logic [31:0]    ret_wdata = 32'h0;
  logic           main_tick, core_tick, clock_out_tick, wdt_tick, wkt_tick;
  logic           pll_locked, pll_powered, irc_out_en, flash_standby, flash_off;
  logic           core_power_off, wkt_running, wkt_timeout;
  logic [15:0]    periph_tick, pmask;
  cpmc_state_t    power_state;
  logic [31:0]    ret_rdata;
  logic [31:0]    rv [4];
  int             fails = 0, total_checks = 0, n_main, n_out, n_core, k, v, n_wdt, n_wkt;

  always #4 clk = ~clk;

  cpmc_osc_model u_osc (.clk, .rst, .ticks);

  cpmc_top #(.LOCK_CYC(8)) dut (
    .clk, .rst, .ticks, .clk_cfg, .osc_cfg, .wdt_freq_sel, .periph_clk_en, .mode_req,
    .mode_sel, .dpd_lock, .wake_irq, .wake_en, .irq_ctrl_en, .any_irq, .wake_pin_n,
    .wkt_load, .wkt_value, .ret_we, .ret_idx, .ret_wdata, .main_tick, .core_tick,
    .periph_tick, .clock_out_tick, .wdt_tick, .wkt_tick, .pll_locked, .pll_powered,
    .irc_out_en, .flash_standby, .flash_off, .core_power_off, .wkt_running,
    .wkt_timeout, .power_state, .ret_rdata
  );

  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Tick counts over a window of n edges
  task automatic count(input int n);
    n_main = 0;
    n_out = 0;
    n_core = 0;
    n_wdt = 0;
    n_wkt = 0;
    pmask = '0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      n_main += main_tick;
      n_out += clock_out_tick;
      n_core += core_tick;
      n_wdt += wdt_tick;
      n_wkt += wkt_tick;
      pmask |= periph_tick;
    end
    @(negedge clk);
  endtask : count

  task automatic req(input cpmc_req_mode_t m);
    @(negedge clk);
    mode_sel = m;
    mode_req = 1'b1;
    @(negedge clk);
    mode_req = 1'b0;
    cyc(3);
  endtask : req

  task automatic wait_run(input int lim);
    int i;
    for (i = 0; i < lim; i++)
      if (power_state !== CPMC_ST_RUN)
        @(negedge clk);
    chk(power_state, CPMC_ST_RUN);
  endtask : wait_run

  // Periods of the clock-out choices with the main clock on RC
  function automatic int out_per(input int s);
    case (s)
      1: return 4;
      2: return 16;
      default: return 2;
    endcase
  endfunction : out_per

  initial
  begin
    #160000;
    fails++;
    give_verdict();
  end

  initial
  begin
    v = $urandom(32'h9A00);
    cyc(20);
    rst = 1'b0;
    chk(pll_powered, 0);
    chk(pll_locked, 0);
    count(40);
    chk(n_main, 20);
    chk(n_wdt, 3);
    chk(n_wkt, 10);
    for (k = 0; k < 4; k++)
    begin
      clk_cfg.out_sel = cpmc_out_sel_t'(k);
      cyc(20);
      count(64);
      chk(n_out, 64 / out_per(k));
    end
    for (k = 0; k < 3; k++)
    begin
      periph_clk_en = (k == 0) ? 16'h0000 : 16'($urandom);
      count(64);
      chk(pmask, periph_clk_en);
    end
    for (k = 1; k < 4; k++)
    begin
      clk_cfg.pll_src = (k == 3) ? CPMC_PLLSRC_EXT : CPMC_PLLSRC_XTAL;
      clk_cfg.main_sel = (k == 1) ? CPMC_MAIN_WDT : CPMC_MAIN_PLLIN;
      cyc(40);
      count(128);
      chk(n_main, 128 >> ((k == 1) ? 4 : k));
      clk_cfg.main_sel = CPMC_MAIN_IRC;
      cyc(20);
    end
    clk_cfg.pll_enable = 1'b1;
    for (k = 0; k < 40 && pll_locked !== 1'b1; k++)
      @(negedge clk);
    chk(pll_locked, 1);
    clk_cfg.main_sel = CPMC_MAIN_PLLOUT;
    for (v = 0; v < 4; v++)
    begin
      clk_cfg.pll_mult_m1 = 5'($urandom_range(31, 0));
      clk_cfg.pll_post_log2m1 = v[1:0];
      cyc(80);
      count(128);
      chk(n_main, 128 / (4 << v));
    end
    clk_cfg.main_sel = CPMC_MAIN_IRC;
    periph_clk_en = 16'hFFFF;
    cyc(20);
    req(CPMC_REQ_SLEEP);
    count(32);
    chk(n_core, 0);
    chk(pmask, 16'hFFFF);
    any_irq = 1'b1;
    wait_run(10);
    any_irq = 1'b0;
    count(32);
    chk(n_core, 16);
    for (k = 0; k < 5; k++)
    begin
      req(k[0] ? CPMC_REQ_POWER_DOWN : CPMC_REQ_DEEP_SLEEP);
      wake_irq = 5'h01 << k;
      wake_en = 5'h01 << k;
      cyc(5);
      chk(power_state, k[0] ? CPMC_ST_PDOWN : CPMC_ST_DSLEEP);
      chk(k[0] ? flash_off : flash_standby, 1);
      irq_ctrl_en = 5'h01 << k;
      wait_run(10);
      wake_irq = 5'h00;
      irq_ctrl_en = 5'h00;
    end
    ret_we = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      rv[k] = $urandom;
      ret_idx = k[1:0];
      ret_wdata = rv[k];
      cyc(1);
    end
    ret_we = 1'b0;
    dpd_lock = 1'b1;
    req(CPMC_REQ_DEEP_PD);
    chk(power_state, CPMC_ST_RUN);
    dpd_lock = 1'b0;
    req(CPMC_REQ_DEEP_PD);
    chk(power_state, CPMC_ST_DPD);
    chk(core_power_off, 1);
    wake_pin_n = 1'b0;
    wait_run(10);
    wake_pin_n = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      ret_idx = k[1:0];
      cyc(2);
      chk(ret_rdata, rv[k]);
    end
    wkt_value = $urandom_range(40, 8);
    wkt_load = 1'b1;
    cyc(1);
    wkt_load = 1'b0;
    cyc(2);
    chk(wkt_running, 1);
    req(CPMC_REQ_DEEP_PD);
    chk(power_state, CPMC_ST_DPD);
    wait_run(400);
    rst = 1'b1;
    cyc(2);
    chk(pll_powered, 0);
    rst = 1'b0;
    count(40);
    chk(n_main, 20);
    give_verdict();
  end
endmodule : tb
